// ---- dv/mscac_host_model.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------------
// serial host: writes the speed command registers by strobe
// ------------------------------------------------------------------
module mscac_host_model (
  input  wire logic                 sys_clk,
  output mscac_pkg::mscac_regwr_type regWr
);
  import mscac_pkg::*;

  // idle bus: no strobe, data zero
  initial begin
    regWr = '0;
  end

  // one register write: strobe held over exactly one rising edge
  task automatic write_reg(input logic high, input logic [7:0] val);
    @(negedge sys_clk);
    regWr.highWr = high;
    regWr.lowWr  = ~high;
    regWr.data   = val;
    @(negedge sys_clk);
    regWr.highWr = 1'b0;
    regWr.lowWr  = 1'b0;
    // released data no longer holds the last value
    regWr.data   = ~val;
  endtask

  // full command: staged top bit first, then the low byte
  task automatic write_cmd(input logic [CMD_W-1:0] cmd);
    write_reg(1'b1, {7'h00, cmd[8]});
    write_reg(1'b0, cmd[7:0]);
  endtask
endmodule

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin numErrors++; \
  $display("unexpected at %0t: got %0h want %0h", $time, got, exp); end end
module tb_top;
  import mscac_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic            sys_clk, nrst;
  mscac_cfg_type   cfg;
  mscac_regwr_type regWr;
  logic [7:0]      regLowRd, regHighRd;
  logic [CMD_W-1:0] pinPwm, pinAna, accelAmp, bemf, amp;
  logic            closedLoop, accelHit, ocInd, zcValid, faultClear;
  logic [FB_W-1:0] curFb, fbOut;
  logic [CUR_W-1:0] lowCur;
  logic [CYC_W-1:0] zcDelay, advCyc;
  logic            commutateNow, driveEnable, lockActive, connFault, mechFault;
  int              numErrors, comparisons;

  mscac_host_model hostModel (.sys_clk(sys_clk), .regWr(regWr));

  mscac_ctrl #(.LOCK_OFF(50), .SLEW_BASE(4)) dut (
    .sys_clk(sys_clk), .nrst(nrst), .cfg(cfg), .regWr(regWr),
    .regLowRd(regLowRd), .regHighRd(regHighRd), .pinPwmCmd(pinPwm),
    .pinAnalogCmd(pinAna), .closedLoop(closedLoop), .accelLimitHit(accelHit),
    .accelLimitAmp(accelAmp), .bemfAmplitude(bemf), .currentFb(curFb),
    .lowSideCurrent(lowCur), .overcurrentIndication(ocInd), .zcPredictValid(zcValid),
    .zcPredictDelay(zcDelay), .faultClear(faultClear), .driveAmplitude(amp),
    .feedbackOut(fbOut), .advanceCycles(advCyc), .commutateNow(commutateNow),
    .driveEnable(driveEnable), .lockActive(lockActive), .connectionFault(connFault),
    .mechanicalFault(mechFault));

  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic finish_test();
    if (numErrors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_vals();
    `CHK(regLowRd, REG_RESET)
    `CHK(regHighRd, REG_RESET)
    `CHK(amp, CMD_RESET)
    `CHK({lockActive, connFault, mechFault}, 3'h0)
  endtask

  // staged top bit, low byte commits, pin ignored
  task automatic t_serial();
    cfg.serialSpeedSelect = 1'b1;
    pinPwm = 9'h123;
    hostModel.write_cmd(9'h0aa);
    wait_cyc(4);
    `CHK(amp, 9'h0aa)
    hostModel.write_reg(1'b1, 8'h01);
    pinPwm = 9'h1c4;
    cfg.speedInputType = 1'b1;
    wait_cyc(4);
    `CHK(regHighRd, 8'h01)
    `CHK(amp, 9'h0aa)
    hostModel.write_reg(1'b0, 8'hff);
    wait_cyc(4);
    `CHK(regLowRd, 8'hff)
    `CHK(amp, CMD_MAX)
    `CHK(amp, CMD_MAX)
  endtask

  // fixed and scaled advance, U = 1ff
  task automatic t_advance();
    cfg.advanceTimeCode = 7'h29;
    wait_cyc(3);
    `CHK(advCyc, 20'h04650)
    cfg.advanceTimeCode = 7'h7f;
    wait_cyc(3);
    `CHK(advCyc, 20'hea600)
    cfg.advanceTimeCode = 7'h29;
    cfg.advanceModeSelect = 1'b1;
    bemf = 9'h0ff;
    wait_cyc(3);
    `CHK(advCyc, 20'h02328)
    bemf = 9'h1ff;
    wait_cyc(3);
    `CHK(advCyc, 20'h00000)
    cfg.advanceModeSelect = 1'b0;
    bemf = 9'h000;
  endtask

  // pin interpretation per input type
  task automatic t_pin();
    cfg.serialSpeedSelect = 1'b0;
    pinPwm = 9'h155;
    pinAna = 9'h0c3;
    wait_cyc(4);
    `CHK(amp, 9'h155)
    cfg.speedInputType = 1'b0;
    wait_cyc(4);
    `CHK(amp, 9'h0c3)
  endtask

  // closed loop: one step per 4 cycles at the fastest rate
  task automatic t_slew();
    closedLoop = 1'b1;
    cfg.closedLoopSlewRate = 3'h7;
    wait_cyc(4);
    pinAna = 9'h0d3;
    wait_cyc(20);
    `CHK(amp > 9'h0c3 && amp < 9'h0d3, 1'b1)
    wait_cyc(100);
    `CHK(amp, 9'h0d3)
  endtask

  // current cap lowers amplitude, motor keeps running
  task automatic t_accel();
    accelAmp = 9'h040;
    accelHit = 1'b1;
    wait_cyc(4);
    `CHK(amp <= 9'h040, 1'b1)
    `CHK({driveEnable, connFault, mechFault}, 3'h4)
    accelHit = 1'b0;
    closedLoop = 1'b0;
  endtask

  task automatic t_feedback();
    curFb = 12'hc5a;
    for (int a = 0; a < 4; a++) begin
      cfg.feedbackAttenuation = 2'(a);
      wait_cyc(2);
      `CHK(fbOut, 12'hc5a >> a)
    end
  endtask

  // 500 cycle advance, zero cross 600 ahead: one pulse near 100
  task automatic t_zero_cross();
    int n;
    cfg.advanceTimeCode = 7'h01;
    zcDelay = 20'h00258;
    wait_cyc(2);
    zcValid = 1'b1;
    wait_cyc(1);
    zcValid = 1'b0;
    n = 1;
    while (commutateNow !== 1'b1 && n < 200) begin
      wait_cyc(1);
      n++;
    end
    // no pulse at all: give up and report
    if (n >= 200) begin
      numErrors++;
      finish_test();
    end
    `CHK(n >= 95 && n <= 105, 1'b1)
    n = 0;
    repeat (30) begin
      wait_cyc(1);
      if (commutateNow === 1'b1) n++;
    end
    `CHK(n, 0)
  endtask

  // trip, auto resume, sticky connection fault
  task automatic t_overcurrent();
    cfg.lockCurrentThreshold = 3'h0;
    ocInd = 1'b1;
    wait_cyc(2);
    `CHK({driveEnable, connFault}, 2'h1)
    ocInd = 1'b0;
    wait_cyc(2);
    `CHK({driveEnable, connFault, mechFault}, 3'h6)
    faultClear = 1'b1;
    wait_cyc(1);
    faultClear = 1'b0;
    wait_cyc(1);
    `CHK(connFault, 1'b0)
  endtask

  // threshold code 2, retry after 50 cycles
  task automatic t_lock();
    int n;
    cfg.lockCurrentThreshold = 3'h2;
    lowCur = 8'h40;
    wait_cyc(3);
    `CHK(lockActive, 1'b0)
    lowCur = 8'h41;
    wait_cyc(2);
    lowCur = 8'h00;
    `CHK({lockActive, driveEnable, mechFault}, 3'h5)
    wait_cyc(30);
    `CHK(lockActive, 1'b1)
    n = 0;
    while (lockActive !== 1'b0 && n < 60) begin
      wait_cyc(1);
      n++;
    end
    if (n >= 60) begin
      numErrors++;
      finish_test();
    end
    wait_cyc(2);
    `CHK({driveEnable, mechFault}, 2'h3)
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    numErrors = 0;
    comparisons = 0;
    nrst = 1'b0;
    cfg = '0;
    cfg.lockCurrentThreshold = 3'h7;
    {pinPwm, pinAna, accelAmp, bemf} = '0;
    {closedLoop, accelHit, ocInd, zcValid, faultClear} = '0;
    {curFb, lowCur, zcDelay} = '0;
    wait_cyc(3);
    nrst = 1'b1;
    wait_cyc(2);
    t_reset_vals();
    t_serial();
    t_advance();
    t_pin();
    t_slew();
    t_accel();
    t_feedback();
    t_zero_cross();
    t_overcurrent();
    t_lock();
    finish_test();
  end
endmodule

// ---- rtl/mscac_ctrl.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Overview of operation
// - serial_speed_select bit picks register speed command
// - register mode ignores the speed pin
// - 9-bit command sets drive amplitude
// - all ones is maximum command
// - high register write only stages bit
// - low register write updates active command
// - closed loop command slew rate limited
// - feedback attenuated by 2-bit shift
// - mode 0 advance equals base setting
// - mode 1 scales by (U-BEMF)/U
// - base is 2.5us mantissa shifted exponent
// - overcurrent always on, fixed threshold
// - short circuit stops, resumes, connection fault
// - lock trip stops, locks, mechanical fault
// - accel limit lowers closed loop amplitude, no fault
// - pin type selects pwm or analog
// - low-side current over threshold trips lock
// ------------------------------------------------------------------
module mscac_ctrl #(
  parameter int LOCK_OFF = mscac_pkg::LOCK_OFF_CYC,
  parameter int SLEW_BASE = mscac_pkg::SLEW_BASE_CYC
) (
  input  wire logic                              sys_clk,
  input  wire logic                              nrst,
  input  wire mscac_pkg::mscac_cfg_type          cfg,
  input  wire mscac_pkg::mscac_regwr_type        regWr,
  output logic [7:0]                             regLowRd,
  output logic [7:0]                             regHighRd,
  input  wire logic [mscac_pkg::CMD_W-1:0]       pinPwmCmd,
  input  wire logic [mscac_pkg::CMD_W-1:0]       pinAnalogCmd,
  input  wire logic                              closedLoop,
  input  wire logic                              accelLimitHit,
  input  wire logic [mscac_pkg::CMD_W-1:0]       accelLimitAmp,
  input  wire logic [mscac_pkg::CMD_W-1:0]       bemfAmplitude,
  input  wire logic [mscac_pkg::FB_W-1:0]        currentFb,
  input  wire logic [mscac_pkg::CUR_W-1:0]       lowSideCurrent,
  input  wire logic                              overcurrentIndication,
  input  wire logic                              zcPredictValid,
  input  wire logic [mscac_pkg::CYC_W-1:0]       zcPredictDelay,
  input  wire logic                              faultClear,
  output logic [mscac_pkg::CMD_W-1:0]            driveAmplitude,
  output logic [mscac_pkg::FB_W-1:0]             feedbackOut,
  output logic [mscac_pkg::CYC_W-1:0]            advanceCycles,
  output logic                                   commutateNow,
  output logic                                   driveEnable,
  output logic                                   lockActive,
  output logic                                   connectionFault,
  output logic                                   mechanicalFault
);
  import mscac_pkg::*;

  // ----------------------------------------------------------------
  // command registers
  // ----------------------------------------------------------------
  logic [7:0]       cmdLow_q;    // speed_command_low contents
  logic [7:0]       cmdHigh_q;   // speed_command_high contents
  logic [CMD_W-1:0] serialCmd_q; // active serial command

  // stage high bit, commit on low write
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cmdLow_q    <= REG_RESET;
      cmdHigh_q   <= REG_RESET;
      serialCmd_q <= CMD_RESET;
    end else begin
      if (regWr.highWr) begin
        cmdHigh_q <= regWr.data;
      end
      if (regWr.lowWr) begin
        cmdLow_q    <= regWr.data;
        serialCmd_q <= {cmdHigh_q[0], regWr.data};
      end
    end
  end

  assign regLowRd  = cmdLow_q;
  assign regHighRd = {7'h00, cmdHigh_q[0]};

  // ----------------------------------------------------------------
  // command source selection
  // ----------------------------------------------------------------
  wire logic [CMD_W-1:0] pinCmd;     // decoded pin command
  wire logic [CMD_W-1:0] targetCmd;  // command before slewing

  assign pinCmd    = cfg.speedInputType ? pinPwmCmd : pinAnalogCmd;
  assign targetCmd = cfg.serialSpeedSelect ? serialCmd_q : pinCmd;

  // ----------------------------------------------------------------
  // closed loop slew limiter
  // ----------------------------------------------------------------
  logic [23:0]      slewCnt_q;  // cycles since last step
  logic [CMD_W-1:0] effCmd_q;   // slewed command
  wire logic [23:0] slewPeriod; // step spacing for this rate
  wire logic        slewTick;   // one step allowed

  // higher rate code gives shorter spacing
  assign slewPeriod = 24'(SLEW_BASE) << (3'h7 - cfg.closedLoopSlewRate);
  assign slewTick   = (slewCnt_q >= slewPeriod - 24'h1);

  // step one lsb toward the target per tick in closed loop
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      slewCnt_q <= 24'h0;
      effCmd_q  <= CMD_RESET;
    end else begin
      slewCnt_q <= slewTick ? 24'h0 : slewCnt_q + 24'h1;
      if (!closedLoop) begin
        effCmd_q <= targetCmd;
      end else if (slewTick && effCmd_q < targetCmd) begin
        effCmd_q <= effCmd_q + 9'h1;
      end else if (slewTick && effCmd_q > targetCmd) begin
        effCmd_q <= effCmd_q - 9'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // drive amplitude
  // ----------------------------------------------------------------
  wire logic             accelClamp;  // closed loop current clamp
  wire logic [CMD_W-1:0] ampNext;     // amplitude after clamp

  // command maps linearly to amplitude, 1ff is full scale
  assign accelClamp = closedLoop && accelLimitHit && (accelLimitAmp < effCmd_q);
  assign ampNext    = accelClamp ? accelLimitAmp : effCmd_q;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      driveAmplitude <= CMD_RESET;
    end else begin
      driveAmplitude <= ampNext;
    end
  end

  // ----------------------------------------------------------------
  // feedback attenuation
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      feedbackOut <= '0;
    end else begin
      feedbackOut <= currentFb >> cfg.feedbackAttenuation;
    end
  end

  // ----------------------------------------------------------------
  // advance time
  // ----------------------------------------------------------------
  wire logic [3:0]        advMant;    // mantissa field
  wire logic [2:0]        advExp;     // exponent field
  wire logic [UNIT_W-1:0] baseUnits;  // base advance in 2.5 us units
  wire logic [19:0]       scaledNum;  // base times (U - BEMF)
  wire logic [UNIT_W-1:0] modeUnits;  // selected advance units
  wire logic              bemfBelow;  // phase amplitude above bemf

  assign advMant   = cfg.advanceTimeCode[ADV_MANT_LSB +: 4];
  assign advExp    = cfg.advanceTimeCode[ADV_EXP_LSB +: 3];
  assign baseUnits = UNIT_W'(advMant) << advExp;
  assign bemfBelow = (driveAmplitude > bemfAmplitude);
  assign scaledNum = 20'(baseUnits) * 20'(driveAmplitude - bemfAmplitude);
  assign modeUnits = !cfg.advanceModeSelect ? baseUnits :
                     bemfBelow ? UNIT_W'(scaledNum / 20'(driveAmplitude)) :
                     '0;

  // units to cycles, one unit is 500 cycles
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      advanceCycles <= '0;
    end else begin
      advanceCycles <= CYC_W'(modeUnits) * CYC_W'(ADV_UNIT_CYC);
    end
  end

  // ----------------------------------------------------------------
  // commutation timing
  // ----------------------------------------------------------------
  logic [CYC_W-1:0] zcCnt_q;  // cycles left to predicted zero cross
  logic             armed_q;  // waiting to commutate
  wire logic        fireNow;  // advance point reached

  assign fireNow = armed_q && (zcCnt_q <= advanceCycles);

  // count down and fire the advance before the zero cross
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      zcCnt_q      <= '0;
      armed_q      <= 1'b0;
      commutateNow <= 1'b0;
    end else begin
      commutateNow <= fireNow && driveEnable;
      if (zcPredictValid) begin
        zcCnt_q <= zcPredictDelay;
        armed_q <= 1'b1;
      end else begin
        if (zcCnt_q != '0) begin
          zcCnt_q <= zcCnt_q - CYC_W'(1);
        end
        if (fireNow) begin
          armed_q <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // protection and lock state
  // ----------------------------------------------------------------
  mscac_state_type state_q;      // lock state
  mscac_state_type state_d;      // next lock state
  logic [23:0]     lockCnt_q;    // lock off wait counter
  wire logic       lockTrip;     // current over lock threshold
  wire logic       lockDone;     // retry wait elapsed

  assign lockTrip = lowSideCurrent > LOCK_THR[cfg.lockCurrentThreshold];
  assign lockDone = (lockCnt_q >= 24'(LOCK_OFF) - 24'h1);

  // next state of the lock machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (lockTrip) begin
          state_d = ST_LOCKED;
        end
      end
      ST_LOCKED: begin
        if (lockDone) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  // state, wait counter, drive gate and sticky faults
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_q         <= ST_RUN;
      lockCnt_q       <= 24'h0;
      driveEnable     <= 1'b0;
      connectionFault <= 1'b0;
      mechanicalFault <= 1'b0;
    end else begin
      state_q   <= state_d;
      lockCnt_q <= (state_q == ST_LOCKED) ? lockCnt_q + 24'h1 : 24'h0;
      // overcurrent has no enable and no threshold setting
      driveEnable <= !overcurrentIndication && (state_d == ST_RUN);
      // set wins over clear
      connectionFault <= overcurrentIndication || (connectionFault && !faultClear);
      mechanicalFault <= (state_q == ST_RUN && lockTrip) ||
                         (mechanicalFault && !faultClear);
    end
  end

  assign lockActive = (state_q == ST_LOCKED);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_high_write_staged: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    regWr.highWr && !regWr.lowWr |=> $stable(serialCmd_q))
    else $error("high register write changed active command");

  a_low_write_commit: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    regWr.lowWr |=> serialCmd_q == {$past(cmdHigh_q[0]), $past(regWr.data)})
    else $error("low register write did not update command");

  a_serial_source: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    cfg.serialSpeedSelect && !closedLoop |=> effCmd_q == $past(serialCmd_q))
    else $error("serial command not selected");

  a_pin_ignored: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    cfg.serialSpeedSelect && $changed(pinPwmCmd) && $stable(serialCmd_q)
    && !regWr.lowWr && !closedLoop ##1 cfg.serialSpeedSelect && !closedLoop |=> $stable(effCmd_q))
    else $error("pin influenced serial mode command");

  a_slew_step: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    closedLoop && $past(closedLoop) && !$past(slewTick) |-> $stable(effCmd_q))
    else $error("command moved without a slew step");

  a_feedback_shift: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    ##1 feedbackOut == ($past(currentFb) >> $past(cfg.feedbackAttenuation)))
    else $error("feedback attenuation wrong");

  a_adv_fixed: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    !cfg.advanceModeSelect |=>
    advanceCycles == CYC_W'($past(baseUnits)) * CYC_W'(ADV_UNIT_CYC))
    else $error("fixed advance mismatch");

  a_overcurrent_stop: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    overcurrentIndication |=> !driveEnable && connectionFault)
    else $error("overcurrent did not stop drive");

  a_lock_stop: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    state_q == ST_RUN && lockTrip |=> lockActive && !driveEnable && mechanicalFault)
    else $error("lock trip did not stop drive");

  a_accel_no_fault: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    accelClamp && !lockTrip && !overcurrentIndication && state_q == ST_RUN
    |=> driveAmplitude == $past(accelLimitAmp) && driveEnable)
    else $error("accel limit misbehaved");

  a_pin_source: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    !cfg.serialSpeedSelect && !closedLoop |=> effCmd_q ==
    ($past(cfg.speedInputType) ? $past(pinPwmCmd) : $past(pinAnalogCmd)))
    else $error("pin command source wrong");

  a_lock_below: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    state_q == ST_RUN && lowSideCurrent <= LOCK_THR[cfg.lockCurrentThreshold] |=> !lockActive)
    else $error("lock tripped below threshold");

  a_drive_resume: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    state_q == ST_RUN && !lockTrip && !overcurrentIndication |=> driveEnable)
    else $error("drive did not resume");

  a_adv_scaled: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    cfg.advanceModeSelect |=>
    advanceCycles <= CYC_W'($past(baseUnits)) * CYC_W'(ADV_UNIT_CYC))
    else $error("scaled advance above base setting");

  a_amp_follow: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    !accelClamp |=> driveAmplitude == $past(effCmd_q))
    else $error("amplitude does not follow command");

endmodule

// ---- rtl/mscac_pkg.sv ----
package mscac_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int CMD_W  = 9;   // speed command width
  localparam int ADV_W  = 7;   // advance time code width
  localparam int UNIT_W = 11;  // advance in 2.5 us units
  localparam int CYC_W  = 20;  // advance / zero-cross counts in cycles
  localparam int FB_W   = 12;  // current feedback width
  localparam int CUR_W  = 8;   // low-side current sample width

  // ----------------------------------------------------------------
  // field positions of the advance time code
  // ----------------------------------------------------------------
  localparam int ADV_MANT_LSB = 0;  // mantissa [3:0]
  localparam int ADV_EXP_LSB  = 4;  // exponent [6:4]

  // ----------------------------------------------------------------
  // reset values and command limits
  // ----------------------------------------------------------------
  localparam logic [CMD_W-1:0] CMD_RESET = 9'h000;  // stopped
  localparam logic [CMD_W-1:0] CMD_MAX   = 9'h1ff;  // full speed
  localparam logic [7:0]       REG_RESET = 8'h00;   // both command registers

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;  // 200 MHz
  localparam int ADV_UNIT_PS   = 2500000;  // 2.5 us advance step
  localparam logic [9:0] ADV_UNIT_CYC = 10'(ADV_UNIT_PS / CLK_PERIOD_PS);
  localparam int LOCK_OFF_CYC  = 200000;  // retry wait after lock trip
  localparam int SLEW_BASE_CYC = 2000;    // fastest slew step spacing

  // lock current thresholds, one per threshold code
  localparam logic [CUR_W-1:0] LOCK_THR [8] = '{
    8'h20, 8'h30, 8'h40, 8'h50, 8'h60, 8'h80, 8'ha0, 8'hc0};

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  // static configuration bits
  typedef struct packed {
    logic             serialSpeedSelect;    // 1: command from registers
    logic             speedInputType;       // 1: pwm duty, 0: analog
    logic [2:0]       closedLoopSlewRate;   // command slew rate
    logic [1:0]       feedbackAttenuation;  // feedback shift
    logic             advanceModeSelect;    // 0: fixed, 1: bemf scaled
    logic [ADV_W-1:0] advanceTimeCode;      // exponent and mantissa
    logic [2:0]       lockCurrentThreshold; // lock trip level
  } mscac_cfg_type;

  // register write port
  typedef struct packed {
    logic       lowWr;   // write speed_command_low
    logic       highWr;  // write speed_command_high
    logic [7:0] data;    // write data
  } mscac_regwr_type;

  // lock state machine
  typedef enum logic [0:0] {
    ST_RUN    = 1'b0,
    ST_LOCKED = 1'b1
  } mscac_state_type;

endpackage
